// *** rtl/dp_pkg.sv ***
package dp_pkg;

  // Sizes of the slice.
  localparam int DATA_W     = 8;
  localparam int CFG_W      = 16;
  localparam int CFG_DEPTH  = 8;
  localparam int CFG_ADDR_W = 3;
  localparam int FIFO_DEPTH = 4;

  // Field positions inside one configuration word.
  localparam int ALU_LSB       = 0;
  localparam int SRCA_BIT      = 3;
  localparam int SRCB_LSB      = 4;
  localparam int ACC0_SRC_LSB  = 6;
  localparam int ACC1_SRC_LSB  = 8;
  localparam int DAT0_LD_BIT   = 10;
  localparam int DAT1_LD_BIT   = 11;
  localparam int FIFO0_CAP_BIT = 12;
  localparam int FIFO1_CAP_BIT = 13;
  localparam int CAP_ALU_BIT   = 14;
  localparam int CIN_CHAIN_BIT = 15;

  // Values after reset, and the byte constants that the detectors and overflow checks compare against.
  localparam logic [7:0]  REG_RST  = 8'h00;
  localparam logic [15:0] CFG_RST  = 16'h0000;
  localparam logic [7:0]  ONES     = 8'hff;
  localparam logic [7:0]  POS_MAX  = 8'h7f;
  localparam logic [7:0]  NEG_MIN  = 8'h80;

  // Selection codes of the system access port.
  localparam logic [2:0] SEL_ACCUMULATOR_ZERO   = 3'h0;
  localparam logic [2:0] SEL_ACCUMULATOR_ONE    = 3'h1;
  localparam logic [2:0] SEL_DATA_REGISTER_ZERO = 3'h2;
  localparam logic [2:0] SEL_DATA_REGISTER_ONE  = 3'h3;
  localparam logic [2:0] SEL_BUS_FIFO_ZERO      = 3'h4;
  localparam logic [2:0] SEL_BUS_FIFO_ONE       = 3'h5;

  typedef enum logic [2:0] {
    ALU_INC, ALU_DEC, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_PASS
  } alu_func_t;

  typedef enum logic [1:0] {B_DAT0, B_DAT1, B_ACC0, B_ACC1} operand_b_t;

  typedef enum logic [1:0] {DST_HOLD, DST_ALU, DST_FIFO0, DST_FIFO1} acc_src_t;

endpackage

// *** rtl/bus_byte_fifo.sv ***
`timescale 1ns/1ns
module bus_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       in_valid,
  output wire logic                       in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  output wire logic                       out_valid,
  input  wire logic                       out_ready,
  output wire logic [WIDTH-1:0]           out_data,
  output wire logic [$clog2(DEPTH+1)-1:0] level
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [CW-1:0]    count_reg;
  logic [PW-1:0]    wr_ptr_next;
  logic [PW-1:0]    rd_ptr_next;
  logic [CW-1:0]    count_next;
  wire  logic       push;
  wire  logic       pop;

  // Full and empty come straight from the count, so neither can lie.
  assign in_ready    = (count_reg != CW'(DEPTH));
  assign out_valid   = (count_reg != '0);
  assign push        = in_valid & in_ready;
  assign pop         = out_valid & out_ready;
  assign out_data    = mem_reg[rd_ptr_reg];
  assign level       = count_reg;
  assign wr_ptr_next = (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
  assign rd_ptr_next = (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
  assign count_next  = count_reg + CW'(push) - CW'(pop);

  // Pointers and count; a push and pop in one cycle leave the count alone.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= push ? wr_ptr_next : wr_ptr_reg;
      rd_ptr_reg <= pop ? rd_ptr_next : rd_ptr_reg;
      count_reg  <= count_next;
    end
  end

  // Storage is written only on an accepted push.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

endmodule

// *** rtl/datapath_slice.sv ***
`timescale 1ns/1ns
module datapath_slice #(
  parameter int FIFO_DEPTH = dp_pkg::FIFO_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       cfg_wr_en,
  input  wire logic [2:0] cfg_wr_addr,
  input  wire logic [15:0] cfg_wr_data,
  input  wire logic [2:0] cfg_addr,
  input  wire logic [1:0] fifo_dir,
  input  wire logic       sys_req,
  input  wire logic       sys_write,
  input  wire logic [2:0] sys_sel,
  input  wire logic [7:0] sys_wdata,
  output wire logic       sys_ready,
  output wire logic [7:0] sys_rdata,
  output wire logic       sys_rvalid,
  input  wire logic       carry_in,
  output wire logic       carry_out,
  input  wire logic       eq_chain_in,
  output wire logic       eq_chain_out,
  output wire logic [1:0] cmp_eq,
  output wire logic [1:0] cmp_lt,
  output wire logic [1:0] zero_det,
  output wire logic [1:0] ones_det,
  output wire logic       overflow,
  output wire logic [7:0] alu_out,
  output wire logic       stall
);

  localparam int LW = $clog2(FIFO_DEPTH + 1);

  // Working registers: index 0 and 1 are accumulator_zero/one and
  // data_register_zero/one.
  logic [7:0]  accumulator_reg   [2];
  logic [7:0]  accumulator_next  [2];
  logic [7:0]  data_register_reg [2];
  logic [7:0]  data_register_next[2];
  logic [15:0] cfg_mem_reg       [dp_pkg::CFG_DEPTH];
  logic [1:0]  cmp_eq_reg;
  logic [1:0]  cmp_lt_reg;
  logic [1:0]  zero_reg;
  logic [1:0]  ones_reg;
  logic        overflow_reg;
  logic [7:0]  alu_out_reg;
  logic [7:0]  sys_rdata_reg;
  logic        sys_rvalid_reg;

  // FIFO handshakes, one entry per bus_fifo_zero/one.
  logic [1:0]    f_in_valid;
  logic [1:0]    f_in_ready;
  logic [7:0]    f_in_data  [2];
  logic [1:0]    f_out_valid;
  logic [1:0]    f_out_ready;
  logic [7:0]    f_out_data [2];
  logic [LW-1:0] f_level    [2];

  wire logic [15:0]       active_cfg;
  wire dp_pkg::alu_func_t func;
  wire dp_pkg::operand_b_t srcb;
  wire dp_pkg::acc_src_t  acc_src [2];
  wire logic [1:0]        dat_load;
  wire logic [1:0]        fifo_cap;
  wire logic              cap_alu;
  wire logic              cin;
  wire logic [7:0]        op_a;
  wire logic [7:0]        op_b;
  wire logic [1:0]        want_pop;
  wire logic [1:0]        blocked;
  wire logic              go;
  wire logic              sys_take;
  wire logic              sys_wr_take;
  wire logic [1:0]        sys_fifo_hit;
  wire logic [1:0]        fifo_ready;
  logic [8:0]             alu_wide;
  logic                   alu_ovf;
  logic [7:0]             sys_mux;

  // Chooses an accumulator's next value from its source field.
  function automatic logic [7:0] acc_pick(input dp_pkg::acc_src_t src, input logic [7:0] cur,
                                          input logic [7:0] alu, input logic [7:0] f0,
                                          input logic [7:0] f1, input logic [1:0] f_in_mode);
    logic [7:0] val;
    val = cur;
    case (src)
      dp_pkg::DST_ALU:   val = alu;
      dp_pkg::DST_FIFO0: val = f_in_mode[0] ? f0 : cur;
      dp_pkg::DST_FIFO1: val = f_in_mode[1] ? f1 : cur;
      default:           val = cur;
    endcase
    return val;
  endfunction

  // The routing address picks a fresh configuration word every cycle.
  assign active_cfg = cfg_mem_reg[cfg_addr];
  assign func       = dp_pkg::alu_func_t'(active_cfg[dp_pkg::ALU_LSB +: 3]);
  assign srcb       = dp_pkg::operand_b_t'(active_cfg[dp_pkg::SRCB_LSB +: 2]);
  assign acc_src[0] = dp_pkg::acc_src_t'(active_cfg[dp_pkg::ACC0_SRC_LSB +: 2]);
  assign acc_src[1] = dp_pkg::acc_src_t'(active_cfg[dp_pkg::ACC1_SRC_LSB +: 2]);
  assign dat_load   = {active_cfg[dp_pkg::DAT1_LD_BIT], active_cfg[dp_pkg::DAT0_LD_BIT]};
  assign fifo_cap   = {active_cfg[dp_pkg::FIFO1_CAP_BIT], active_cfg[dp_pkg::FIFO0_CAP_BIT]};
  assign cap_alu    = active_cfg[dp_pkg::CAP_ALU_BIT];
  assign cin        = active_cfg[dp_pkg::CIN_CHAIN_BIT] & carry_in;

  // Operand A is an accumulator; operand B may be any of the four registers.
  assign op_a = active_cfg[dp_pkg::SRCA_BIT] ? accumulator_reg[1] : accumulator_reg[0];
  assign op_b = (srcb == dp_pkg::B_DAT0) ? data_register_reg[0] :
                (srcb == dp_pkg::B_DAT1) ? data_register_reg[1] :
                (srcb == dp_pkg::B_ACC0) ? accumulator_reg[0] : accumulator_reg[1];

  // Single-cycle ALU; the ninth bit is carry out, or borrow for subtraction.
  always_comb begin
    alu_wide = {1'b0, op_a};
    alu_ovf  = 1'b0;
    case (func)
      dp_pkg::ALU_INC: begin
        alu_wide = {1'b0, op_a} + 9'h001;
        alu_ovf  = (op_a == dp_pkg::POS_MAX);
      end
      dp_pkg::ALU_DEC: begin
        alu_wide = {1'b0, op_a} - 9'h001;
        alu_ovf  = (op_a == dp_pkg::NEG_MIN);
      end
      dp_pkg::ALU_ADD: begin
        alu_wide = {1'b0, op_a} + {1'b0, op_b} + {8'h00, cin};
        alu_ovf  = (op_a[7] == op_b[7]) && (alu_wide[7] != op_a[7]);
      end
      dp_pkg::ALU_SUB: begin
        alu_wide = {1'b0, op_a} - {1'b0, op_b} - {8'h00, cin};
        alu_ovf  = (op_a[7] != op_b[7]) && (alu_wide[7] != op_a[7]);
      end
      dp_pkg::ALU_AND:  alu_wide = {1'b0, op_a & op_b};
      dp_pkg::ALU_OR:   alu_wide = {1'b0, op_a | op_b};
      dp_pkg::ALU_XOR:  alu_wide = {1'b0, op_a ^ op_b};
      dp_pkg::ALU_PASS: alu_wide = {1'b0, op_a};
      default:          alu_wide = {1'b0, op_a};
    endcase
  end

  // Chain outputs stay combinational so that slices cascade within one cycle.
  assign carry_out    = alu_wide[8];
  assign eq_chain_out = eq_chain_in & (accumulator_reg[0] == data_register_reg[0]);

  // A load from an empty FIFO or a capture into a full one freezes the accumulators,
  // data registers and datapath FIFO transfers for that cycle, so back-pressure reaches the sequencing logic.
  assign want_pop[0] = (acc_src[0] == dp_pkg::DST_FIFO0) | (acc_src[1] == dp_pkg::DST_FIFO0) | dat_load[0];
  assign want_pop[1] = (acc_src[0] == dp_pkg::DST_FIFO1) | (acc_src[1] == dp_pkg::DST_FIFO1) | dat_load[1];
  assign go    = ~|blocked;
  assign stall = ~go;

  // System access: a FIFO in the wrong direction is answered at once and ignored.
  assign sys_fifo_hit[0] = (sys_sel == dp_pkg::SEL_BUS_FIFO_ZERO);
  assign sys_fifo_hit[1] = (sys_sel == dp_pkg::SEL_BUS_FIFO_ONE);
  assign sys_ready   = sys_fifo_hit[0] ? fifo_ready[0] : sys_fifo_hit[1] ? fifo_ready[1] : 1'b1;
  assign sys_take    = sys_req & sys_ready;
  assign sys_wr_take = sys_take & sys_write;
  assign sys_mux = (sys_sel == dp_pkg::SEL_ACCUMULATOR_ZERO)   ? accumulator_reg[0] :
                   (sys_sel == dp_pkg::SEL_ACCUMULATOR_ONE)    ? accumulator_reg[1] :
                   (sys_sel == dp_pkg::SEL_DATA_REGISTER_ZERO) ? data_register_reg[0] :
                   (sys_sel == dp_pkg::SEL_DATA_REGISTER_ONE)  ? data_register_reg[1] :
                   (sys_fifo_hit[0] & fifo_dir[0]) ? f_out_data[0] :
                   (sys_fifo_hit[1] & fifo_dir[1]) ? f_out_data[1] : dp_pkg::REG_RST;

  // Per-index logic for the two FIFOs, accumulators and data registers.
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_lane
      wire logic sys_push;
      wire logic sys_pop;
      wire logic [2:0] acc_sel_code;
      wire logic [2:0] dat_sel_code;

      assign acc_sel_code = i[0] ? dp_pkg::SEL_ACCUMULATOR_ONE : dp_pkg::SEL_ACCUMULATOR_ZERO;
      assign dat_sel_code = i[0] ? dp_pkg::SEL_DATA_REGISTER_ONE : dp_pkg::SEL_DATA_REGISTER_ZERO;
      assign sys_push = sys_take & sys_write & sys_fifo_hit[i] & ~fifo_dir[i];
      assign sys_pop  = sys_take & ~sys_write & sys_fifo_hit[i] & fifo_dir[i];
      // Only the bus side that matches the direction can be held off.
      assign fifo_ready[i] = (sys_write ^ fifo_dir[i]) ? (sys_write ? f_in_ready[i] : f_out_valid[i]) : 1'b1;

      // Input mode: bus fills, datapath drains. Output mode: the reverse.
      assign blocked[i] = fifo_dir[i] ? (fifo_cap[i] & ~f_in_ready[i]) : (want_pop[i] & ~f_out_valid[i]);
      assign f_in_valid[i]  = fifo_dir[i] ? (fifo_cap[i] & go) : sys_push;
      assign f_in_data[i]   = fifo_dir[i] ? (cap_alu ? alu_wide[7:0] : accumulator_reg[i]) : sys_wdata;
      assign f_out_ready[i] = fifo_dir[i] ? sys_pop : (want_pop[i] & go);

      // A firmware write wins over the datapath in the same cycle.
      assign accumulator_next[i] =
        (sys_wr_take & (sys_sel == acc_sel_code)) ? sys_wdata :
        go ? acc_pick(acc_src[i], accumulator_reg[i], alu_wide[7:0], f_out_data[0], f_out_data[1],
                      ~fifo_dir) : accumulator_reg[i];
      // Data registers take firmware or their own FIFO, never the ALU.
      assign data_register_next[i] =
        (sys_wr_take & (sys_sel == dat_sel_code)) ? sys_wdata :
        (go & dat_load[i] & ~fifo_dir[i]) ? f_out_data[i] : data_register_reg[i];

      bus_byte_fifo #(
        .WIDTH (dp_pkg::DATA_W),
        .DEPTH (FIFO_DEPTH)
      ) u_bus_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (f_in_valid[i]),
        .in_ready  (f_in_ready[i]),
        .in_data   (f_in_data[i]),
        .out_valid (f_out_valid[i]),
        .out_ready (f_out_ready[i]),
        .out_data  (f_out_data[i]),
        .level     (f_level[i])
      );

      // Conditions follow the register values as they will stand next cycle.
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          accumulator_reg[i]   <= dp_pkg::REG_RST;
          data_register_reg[i] <= dp_pkg::REG_RST;
          cmp_eq_reg[i]        <= 1'b1;
          cmp_lt_reg[i]        <= 1'b0;
          zero_reg[i]          <= 1'b1;
          ones_reg[i]          <= 1'b0;
        end else begin
          accumulator_reg[i]   <= accumulator_next[i];
          data_register_reg[i] <= data_register_next[i];
          cmp_eq_reg[i]        <= (accumulator_next[i] == data_register_next[i]);
          cmp_lt_reg[i]        <= (accumulator_next[i] < data_register_next[i]);
          zero_reg[i]          <= (accumulator_next[i] == dp_pkg::REG_RST);
          ones_reg[i]          <= (accumulator_next[i] == dp_pkg::ONES);
        end
      end
    end
  endgenerate

  // Configuration memory: written from the configuration port, read by address.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < dp_pkg::CFG_DEPTH; k++) begin
        cfg_mem_reg[k] <= dp_pkg::CFG_RST;
      end
    end else if (cfg_wr_en) begin
      cfg_mem_reg[cfg_wr_addr] <= cfg_wr_data;
    end
  end

  // Result, overflow and read data registers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alu_out_reg    <= dp_pkg::REG_RST;
      overflow_reg   <= 1'b0;
      sys_rdata_reg  <= dp_pkg::REG_RST;
      sys_rvalid_reg <= 1'b0;
    end else begin
      alu_out_reg    <= alu_wide[7:0];
      overflow_reg   <= go & alu_ovf;
      sys_rdata_reg  <= (sys_take & ~sys_write) ? sys_mux : sys_rdata_reg;
      sys_rvalid_reg <= sys_take & ~sys_write;
    end
  end

  assign cmp_eq     = cmp_eq_reg;
  assign cmp_lt     = cmp_lt_reg;
  assign zero_det   = zero_reg;
  assign ones_det   = ones_reg;
  assign overflow   = overflow_reg;
  assign alu_out    = alu_out_reg;
  assign sys_rdata  = sys_rdata_reg;
  assign sys_rvalid = sys_rvalid_reg;

  // Checks on the slice, all in the clk domain.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_cfg_written;
    cfg_wr_en ##1 (cfg_addr == $past(cfg_wr_addr));
  endsequence

  sequence s_acc0_read;
    sys_take & ~sys_write & (sys_sel == dp_pkg::SEL_ACCUMULATOR_ZERO);
  endsequence

  a_alu_add_sum: assert property ((func == dp_pkg::ALU_ADD) |=>
    (alu_out == 8'($past(op_a) + $past(op_b) + {7'h00, $past(cin)})))
    else $error("Add result wrong.");
  a_alu_dec_sum: assert property ((func == dp_pkg::ALU_DEC) |=>
    (alu_out == 8'($past(op_a) - 8'h01)))
    else $error("Decrement result wrong.");
  a_alu_pass_op: assert property ((func == dp_pkg::ALU_PASS) |=> (alu_out == $past(op_a)))
    else $error("Pass altered the operand.");
  a_zero_flag: assert property (zero_det[0] == (accumulator_reg[0] == 8'h00))
    else $error("Zero detect disagrees with accumulator.");
  a_cmp_lt_one: assert property (cmp_lt[1] == (accumulator_reg[1] < data_register_reg[1]))
    else $error("Less-than compare disagrees with registers.");
  a_data_not_sink: assert property (go & ~sys_wr_take & ~dat_load[0] |=>
    $stable(data_register_reg[0]))
    else $error("Data register changed without a load.");
  a_stall_holds: assert property (stall & ~sys_wr_take |=>
    $stable(accumulator_reg[0]) && $stable(accumulator_reg[1]))
    else $error("Accumulator moved during a stall.");
  a_fifo_bound: assert property ((f_level[0] <= LW'(FIFO_DEPTH)) && (f_level[1] <= LW'(FIFO_DEPTH)))
    else $error("FIFO holds more than its depth.");
  a_cfg_follow: assert property (s_cfg_written |-> (active_cfg == $past(cfg_wr_data)))
    else $error("Active configuration does not follow the written entry.");
  a_sys_read_acc: assert property (s_acc0_read |=> sys_rvalid ##0
    (sys_rdata == $past(accumulator_reg[0])))
    else $error("Firmware read of accumulator wrong.");

endmodule

// *** bench/sys_master_model.sv ***
`timescale 1ns/1ns
// Stands in for firmware or DMA on the system port of the slice.
module sys_master_model (
  input  wire logic       clk,
  input  wire logic       sys_ready,
  output var  logic       sys_req,
  output var  logic       sys_write,
  output var  logic [2:0] sys_sel,
  output var  logic [7:0] sys_wdata
);
  // Idle until the first request.
  initial begin
    sys_req = 1'b0;
    sys_write = 1'b0;
    sys_sel = 3'h0;
    sys_wdata = 8'h00;
  end

  // One access, held until ready is seen at an edge; ok is low if the wait expired.
  task automatic access(input logic wr, input logic [2:0] sel, input logic [7:0] d, output logic ok);
    int n;
    n = 0;
    @(posedge clk);
    sys_req <= 1'b1;
    sys_write <= wr;
    sys_sel <= sel;
    sys_wdata <= d;
    #1;
    while (sys_ready !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    sys_req <= 1'b0;
    ok = (n < 50);
  endtask

  // Offers a request for one cycle only, to see whether it would be refused.
  task automatic probe(input logic wr, input logic [2:0] sel, output logic rdy);
    @(posedge clk);
    sys_req <= 1'b1;
    sys_write <= wr;
    sys_sel <= sel;
    #1;
    rdy = sys_ready;
    @(posedge clk);
    sys_req <= 1'b0;
  endtask
endmodule

// *** bench/test_programmable_datapath_alu.sv ***
`timescale 1ns/1ns
module test_programmable_datapath_alu;
  logic        clk, rst, cfg_wr_en, sys_req, sys_write, sys_ready, sys_rvalid;
  logic        carry_in, carry_out, eq_chain_in, eq_chain_out, overflow, stall, rdy;
  logic [2:0]  cfg_wr_addr, cfg_addr, sys_sel;
  logic [15:0] cfg_wr_data;
  logic [1:0]  fifo_dir, cmp_eq, cmp_lt, zero_det, ones_det;
  logic [7:0]  sys_wdata, sys_rdata, alu_out, a, d1, e;
  logic [7:0]  q [4];
  logic [8:0]  s;
  logic [7:0]  expq [$];
  logic [31:0] seed;
  int          failures, compares;

  datapath_slice dut (.clk(clk), .rst(rst), .cfg_wr_en(cfg_wr_en), .cfg_wr_addr(cfg_wr_addr),
    .cfg_wr_data(cfg_wr_data), .cfg_addr(cfg_addr), .fifo_dir(fifo_dir), .sys_req(sys_req),
    .sys_write(sys_write), .sys_sel(sys_sel), .sys_wdata(sys_wdata), .sys_ready(sys_ready),
    .sys_rdata(sys_rdata), .sys_rvalid(sys_rvalid), .carry_in(carry_in), .carry_out(carry_out),
    .eq_chain_in(eq_chain_in), .eq_chain_out(eq_chain_out), .cmp_eq(cmp_eq), .cmp_lt(cmp_lt),
    .zero_det(zero_det), .ones_det(ones_det), .overflow(overflow), .alu_out(alu_out), .stall(stall));
  sys_master_model bm (.clk(clk), .sys_ready(sys_ready), .sys_req(sys_req), .sys_write(sys_write),
    .sys_sel(sys_sel), .sys_wdata(sys_wdata));

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic summarize();
    if (failures == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic hang();
    failures++;
    $display("Error at %0t: wait for ready expired", $time);
    summarize();
  endtask

  task automatic wr(input logic [2:0] sel, input logic [7:0] d);
    logic ok;
    bm.access(1'b1, sel, d, ok);
    if (!ok) hang();
  endtask

  task automatic rd(input logic [2:0] sel, input logic [7:0] x);
    logic ok;
    expq.push_back(x);
    bm.access(1'b0, sel, 8'h00, ok);
    if (!ok) hang();
  endtask

  task automatic cfg(input logic [2:0] ad, input logic [15:0] w);
    @(posedge clk);
    cfg_wr_en <= 1'b1;
    cfg_wr_addr <= ad;
    cfg_wr_data <= w;
    @(posedge clk);
    cfg_wr_en <= 1'b0;
  endtask

  // Executes entry ad at exactly one edge, then returns to the harmless entry 0.
  task automatic step(input logic [2:0] ad);
    @(posedge clk);
    cfg_addr <= ad;
    @(posedge clk);
    cfg_addr <= 3'h0;
  endtask

  // Read results arrive one cycle after the request is taken; the oldest note is the one due.
  always @(negedge clk) begin
    if (rst === 1'b0 && sys_rvalid === 1'b1) begin
      if (expq.size() == 0) check(8'hxx, 8'h00, "unasked read");
      else check(sys_rdata, expq.pop_front(), "read data");
    end
  end

  // Main sequence; entry 0 stays all zero, so idle cycles only bump alu_out.
  initial begin
    rst = 1'b1;
    cfg_wr_en = 1'b0;
    cfg_wr_addr = 3'h0;
    cfg_wr_data = 16'h0000;
    cfg_addr = 3'h0;
    fifo_dir = 2'b10;
    carry_in = 1'b0;
    eq_chain_in = 1'b1;
    seed = 32'd75;
    failures = 0;
    compares = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    #1;
    check({cmp_eq, cmp_lt, zero_det, ones_det}, 8'hcc, "reset conditions");
    for (int i = 0; i < 4; i++) rd(i[2:0], 8'h00);
    a = rnd();
    d1 = rnd();
    wr(dp_pkg::SEL_ACCUMULATOR_ZERO, a);
    wr(dp_pkg::SEL_ACCUMULATOR_ONE, 8'hff);
    wr(dp_pkg::SEL_DATA_REGISTER_ZERO, a ^ 8'h01);
    wr(dp_pkg::SEL_DATA_REGISTER_ONE, d1);
    rd(dp_pkg::SEL_ACCUMULATOR_ZERO, a);
    rd(dp_pkg::SEL_ACCUMULATOR_ONE, 8'hff);
    rd(dp_pkg::SEL_DATA_REGISTER_ZERO, a ^ 8'h01);
    rd(dp_pkg::SEL_DATA_REGISTER_ONE, d1);
    rd(3'h6, 8'h00);
    #1;
    check({6'h0, cmp_eq}, {6'h0, d1 == 8'hff, 1'b0}, "equal flags");
    check({6'h0, cmp_lt}, {6'h0, 1'b0, a < (a ^ 8'h01)}, "less flags");
    check({4'h0, zero_det, ones_det}, {4'h0, 1'b0, a == 8'h00, 1'b1, a == 8'hff}, "detects");
    // Every function reads acc0 and data0 and writes nowhere; the carry input must be ignored.
    for (int f = 0; f < 8; f++) cfg(f[2:0], {13'h0, f[2:0]});
    for (int f = 0; f < 8; f++) begin
      case (f)
        0: s = a + 9'h1;
        1: s = a - 9'h1;
        2: s = a + (a ^ 8'h01);
        3: s = a - (a ^ 8'h01);
        4: s = a & (a ^ 8'h01);
        5: s = a | (a ^ 8'h01);
        6: s = a ^ (a ^ 8'h01);
        default: s = {1'b0, a};
      endcase
      @(posedge clk);
      cfg_addr <= f[2:0];
      carry_in <= rnd() > 8'h7f;
      #1;
      if (f == 2 || f == 3) check(carry_out, s[8], "carry");
      @(posedge clk);
      #1;
      check(alu_out, s[7:0], "alu result");
      if (f == 2 || f == 3) check(overflow, s[7] != a[7] && (a[7] == (a[7] ^ (f == 3))), "overflow");
    end
    cfg_addr <= 3'h0;
    carry_in <= 1'b0;
    // Fill the input FIFO until it refuses, then pop it into acc1 one byte at a time.
    for (int i = 0; i < 4; i++) begin
      q[i] = rnd();
      wr(dp_pkg::SEL_BUS_FIFO_ZERO, q[i]);
    end
    bm.probe(1'b1, dp_pkg::SEL_BUS_FIFO_ZERO, rdy);
    check(rdy, 8'h00, "full write ready");
    cfg(3'h1, 16'h0200);
    cfg(3'h2, 16'h6108);
    for (int i = 0; i < 4; i++) begin
      step(3'h1);
      rd(dp_pkg::SEL_ACCUMULATOR_ONE, q[i]);
    end
    @(posedge clk);
    cfg_addr <= 3'h1;
    #1;
    check(stall, 8'h01, "empty stall");
    @(posedge clk);
    cfg_addr <= 3'h2;
    repeat (4) @(posedge clk);
    #1;
    check(stall, 8'h01, "full stall");
    @(posedge clk);
    cfg_addr <= 3'h0;
    for (int i = 1; i < 5; i++) begin
      e = q[3] + i[7:0];
      rd(dp_pkg::SEL_BUS_FIFO_ONE, e);
    end
    rd(dp_pkg::SEL_ACCUMULATOR_ONE, q[3] + 8'h04);
    bm.probe(1'b0, dp_pkg::SEL_BUS_FIFO_ONE, rdy);
    check(rdy, 8'h00, "empty read ready");
    rd(dp_pkg::SEL_BUS_FIFO_ZERO, 8'h00);
    // Chain inputs: equality ripples through, carry enters when bit 15 asks for it.
    wr(dp_pkg::SEL_DATA_REGISTER_ZERO, a);
    #1;
    check({6'h0, cmp_eq[0], eq_chain_out}, 8'h03, "equal chain");
    eq_chain_in <= 1'b0;
    #1;
    check({7'h0, eq_chain_out}, 8'h00, "broken chain");
    cfg(3'h3, 16'h8002);
    @(posedge clk);
    cfg_addr <= 3'h3;
    carry_in <= 1'b1;
    @(posedge clk);
    cfg_addr <= 3'h0;
    #1;
    check(alu_out, a + a + 8'h01, "chained add");
    // Swapped directions: data1 loads from fifo1, acc0 takes acc0 XOR data1, fifo0 captures old acc0.
    fifo_dir <= 2'b01;
    e = rnd();
    wr(dp_pkg::SEL_BUS_FIFO_ONE, e);
    cfg(3'h4, 16'h1856);
    step(3'h4);
    rd(dp_pkg::SEL_ACCUMULATOR_ZERO, a ^ d1);
    rd(dp_pkg::SEL_DATA_REGISTER_ONE, e);
    rd(dp_pkg::SEL_BUS_FIFO_ZERO, a);
    repeat (3) @(posedge clk);
    check(8'(expq.size()), 8'h00, "reads never answered");
    summarize();
  end
endmodule
